// file: include/ipa_pkg.sv
// Purpose: Constants and types for indirect pointer addressing unit
// Assumes: 12-bit data space, three pointer pairs, 8-bit data
// Notes:   Offsets are byte addresses in the special-function space
package ipa_pkg;
  localparam int AW    = 12;
  localparam int DW    = 8;
  localparam int NPAIR = 3;
  // Virtual operand and pointer byte addresses per pair, in pair order 0..2
  localparam logic [11:0] PLAIN_A   [3] = '{12'hFEF, 12'hFE7, 12'hFDF};
  localparam logic [11:0] ACC_DEC_A [3] = '{12'hFED, 12'hFE5, 12'hFDD};
  localparam logic [11:0] ACC_INC_A [3] = '{12'hFEE, 12'hFE6, 12'hFDE};
  localparam logic [11:0] INC_ACC_A [3] = '{12'hFEC, 12'hFE4, 12'hFDC};
  localparam logic [11:0] OFS_ACC_A [3] = '{12'hFEB, 12'hFE3, 12'hFDB};
  localparam logic [11:0] PTR_LO_A  [3] = '{12'hFE9, 12'hFE1, 12'hFD9};
  localparam logic [11:0] PTR_HI_A  [3] = '{12'hFEA, 12'hFE2, 12'hFDA};
  localparam logic [7:0]  PTR_RST   = 8'h00;
  localparam logic [11:0] ONE_A     = 12'h001;
  typedef enum logic [2:0] {
    IPA_OP_NONE    = 3'b000,
    IPA_OP_PLAIN   = 3'b001,
    IPA_OP_ACC_DEC = 3'b010,
    IPA_OP_ACC_INC = 3'b011,
    IPA_OP_INC_ACC = 3'b100,
    IPA_OP_OFS_ACC = 3'b101
  } ipa_op_t;
endpackage : ipa_pkg

// file: include/ipa_ptr_if.sv
// Purpose: Bundle between top and one pointer pair
// Assumes: Single clock domain
// Notes:   Top drives commands, pair drives its value
`timescale 1ns/1ps
interface ipa_ptr_if;
  logic       wr_lo;
  logic       wr_hi;
  logic [7:0] wdata;
  logic       inc;
  logic       dec;
  logic [7:0] lo;
  logic [7:0] hi;
  modport ctrl (output wr_lo, wr_hi, wdata, inc, dec, input lo, hi);
  modport pair (input wr_lo, wr_hi, wdata, inc, dec, output lo, hi);
endinterface : ipa_ptr_if

// file: core/ipa_ptr_pair.sv
// Purpose: One pointer pair, low and high bytes with step logic
// Assumes: Writes win over steps in the same cycle
// Notes:   Step carries across the whole 16-bit pair
`timescale 1ns/1ps
module ipa_ptr_pair (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // Control
  ipa_ptr_if.pair   p
);
  import ipa_pkg::*;
  logic [15:0] val_r;
  logic [15:0] val_nxt;

  always_comb begin
    val_nxt = val_r;
    if (p.inc) begin
      val_nxt = val_r + 16'h0001;
    end else if (p.dec) begin
      val_nxt = val_r - 16'h0001;
    end
    if (p.wr_lo) begin
      val_nxt[7:0] = p.wdata;
    end
    if (p.wr_hi) begin
      val_nxt[15:8] = p.wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      val_r <= {PTR_RST, PTR_RST};
    end else begin
      val_r <= val_nxt;
    end
  end

  assign p.lo = val_r[7:0];
  assign p.hi = val_r[15:8];

  property p_step_carry;
    @(posedge i_clk_sys) disable iff (i_reset)
      (p.inc && !p.wr_lo && !p.wr_hi && val_r[7:0] == 8'hFF)
        |=> val_r[15:8] == $past(val_r[15:8]) + 8'h01;
  endproperty
  a_step_carry: assert property (p_step_carry)
    else $error("pointer increment lost carry");
endmodule : ipa_ptr_pair

// file: core/ipa_indirect.sv
// Purpose: Indirect addressing through three pointer pairs
// Assumes: Core issues at most one access per cycle
// Notes:   Result of each access is registered one cycle later
`timescale 1ns/1ps
module ipa_indirect (
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  // Core access request
  input  wire logic                   i_req,
  input  wire logic                   i_we,
  input  wire logic [ipa_pkg::AW-1:0] i_addr,
  input  wire logic [ipa_pkg::DW-1:0] i_wdata,
  input  wire logic [ipa_pkg::DW-1:0] i_wreg,
  // Memory side request
  output logic                        o_mem_req,
  output logic                        o_mem_we,
  output logic [ipa_pkg::AW-1:0]      o_mem_addr,
  output logic [ipa_pkg::DW-1:0]      o_mem_wdata,
  input  wire logic [ipa_pkg::DW-1:0] i_mem_rdata,
  // Core answer
  output logic                        o_ack,
  output logic [ipa_pkg::DW-1:0]      o_rdata
);
  import ipa_pkg::*;

  ipa_ptr_if pif [NPAIR] ();
  logic [AW-1:0] ptr [NPAIR];

  genvar g;
  generate
    for (g = 0; g < NPAIR; g++) begin : gen_pair
      ipa_ptr_pair ipa_ptr_pair_i (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .p         (pif[g])
      );
      assign ptr[g] = {pif[g].hi[3:0], pif[g].lo};
    end
  endgenerate

  // ****************************************
  // Decode of target address
  // ****************************************
  function automatic logic is_virt(input logic [AW-1:0] a);
    logic r;
    r = 1'b0;
    for (int k = 0; k < NPAIR; k++) begin
      if (a == PLAIN_A[k] || a == ACC_DEC_A[k] || a == ACC_INC_A[k] ||
          a == INC_ACC_A[k] || a == OFS_ACC_A[k]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : is_virt

  ipa_op_t          op;
  logic [1:0]       sel;
  logic [AW-1:0]    eff;
  logic             blocked;
  logic [NPAIR-1:0] hit_lo;
  logic [NPAIR-1:0] hit_hi;
  logic             hit_ptr;
  logic             mem_go;

  always_comb begin
    op  = IPA_OP_NONE;
    sel = 2'd0;
    for (int k = 0; k < NPAIR; k++) begin
      if (i_addr == PLAIN_A[k]) begin
        op = IPA_OP_PLAIN;
        sel = 2'(k);
      end else if (i_addr == ACC_DEC_A[k]) begin
        op = IPA_OP_ACC_DEC;
        sel = 2'(k);
      end else if (i_addr == ACC_INC_A[k]) begin
        op = IPA_OP_ACC_INC;
        sel = 2'(k);
      end else if (i_addr == INC_ACC_A[k]) begin
        op = IPA_OP_INC_ACC;
        sel = 2'(k);
      end else if (i_addr == OFS_ACC_A[k]) begin
        op = IPA_OP_OFS_ACC;
        sel = 2'(k);
      end
    end
    case (op)
      IPA_OP_INC_ACC: begin
        eff = ptr[sel] + ONE_A;
      end
      IPA_OP_OFS_ACC: begin
        eff = ptr[sel] + AW'({{4{i_wreg[7]}}, i_wreg});
      end
      IPA_OP_NONE: begin
        eff = i_addr;
      end
      default: begin
        eff = ptr[sel];
      end
    endcase
    blocked = (op != IPA_OP_NONE) && is_virt(eff);
    for (int k = 0; k < NPAIR; k++) begin
      hit_lo[k] = (eff == PTR_LO_A[k]);
      hit_hi[k] = (eff == PTR_HI_A[k]);
    end
    hit_ptr = |{hit_lo, hit_hi};
    mem_go = i_req && !blocked && !hit_ptr;
  end

  // ****************************************
  // Pointer updates
  // ****************************************
  logic [NPAIR-1:0] wr_lo_c;
  logic [NPAIR-1:0] wr_hi_c;
  logic [NPAIR-1:0] inc_c;
  logic [NPAIR-1:0] dec_c;
  logic             own_wr;

  always_comb begin
    own_wr = i_req && i_we && !blocked &&
             (hit_lo[sel] || hit_hi[sel]) && op != IPA_OP_NONE;
    for (int k = 0; k < NPAIR; k++) begin
      wr_lo_c[k] = i_req && i_we && !blocked && hit_lo[k];
      wr_hi_c[k] = i_req && i_we && !blocked && hit_hi[k];
      // Writes onto own pair suppress stepping; no flags exist here
      inc_c[k] = i_req && !blocked && !own_wr && sel == 2'(k) &&
                 (op == IPA_OP_ACC_INC || op == IPA_OP_INC_ACC);
      dec_c[k] = i_req && !blocked && !own_wr && sel == 2'(k) &&
                 op == IPA_OP_ACC_DEC;
    end
  end

  generate
    for (g = 0; g < NPAIR; g++) begin : gen_ctl
      assign pif[g].wr_lo = wr_lo_c[g];
      assign pif[g].wr_hi = wr_hi_c[g];
      assign pif[g].wdata = i_wdata;
      assign pif[g].inc   = inc_c[g];
      assign pif[g].dec   = dec_c[g];
    end
  endgenerate

  // ****************************************
  // Registered outputs
  // ****************************************
  logic          mreq_r, mreq_nxt, mwe_r, mwe_nxt, ack_r, ack_nxt;
  logic [AW-1:0] maddr_r, maddr_nxt;
  logic [DW-1:0] mwd_r, mwd_nxt;
  logic          fromptr_r, fromptr_nxt;
  logic [DW-1:0] pval_r, pval_nxt;

  always_comb begin
    mreq_nxt    = mem_go;
    mwe_nxt     = mem_go && i_we;
    maddr_nxt   = mem_go ? eff : maddr_r;
    mwd_nxt     = i_wdata;
    ack_nxt     = i_req;
    fromptr_nxt = hit_ptr || blocked;
    pval_nxt    = 8'h00;
    for (int k = 0; k < NPAIR; k++) begin
      if (hit_lo[k]) begin
        pval_nxt = ptr_lo_val(k);
      end
      if (hit_hi[k]) begin
        pval_nxt = ptr_hi_val(k);
      end
    end
    if (blocked) begin
      pval_nxt = 8'h00;
    end
  end

  function automatic logic [7:0] ptr_lo_val(input int k);
    return ptr[k][7:0];
  endfunction : ptr_lo_val
  function automatic logic [7:0] ptr_hi_val(input int k);
    return {4'h0, ptr[k][11:8]};
  endfunction : ptr_hi_val

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mreq_r    <= 1'b0;
      mwe_r     <= 1'b0;
      maddr_r   <= '0;
      mwd_r     <= '0;
      ack_r     <= 1'b0;
      fromptr_r <= 1'b0;
      pval_r    <= '0;
    end else begin
      mreq_r    <= mreq_nxt;
      mwe_r     <= mwe_nxt;
      maddr_r   <= maddr_nxt;
      mwd_r     <= mwd_nxt;
      ack_r     <= ack_nxt;
      fromptr_r <= fromptr_nxt;
      pval_r    <= pval_nxt;
    end
  end

  // Read data: memory answers combinationally for the registered request
  always_comb begin
    o_rdata = fromptr_r ? pval_r : i_mem_rdata;
  end
  assign o_mem_req   = mreq_r;
  assign o_mem_we    = mwe_r;
  assign o_mem_addr  = maddr_r;
  assign o_mem_wdata = mwd_r;
  assign o_ack       = ack_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_plain_addr;
    @(posedge i_clk_sys) disable iff (i_reset)
      (mem_go && op == IPA_OP_PLAIN) |=> o_mem_addr == $past(ptr[sel]);
  endproperty
  a_plain_addr: assert property (p_plain_addr)
    else $error("plain access address wrong");

  property p_acc_inc;
    @(posedge i_clk_sys) disable iff (i_reset)
      (inc_c[0] && !wr_lo_c[0] && !wr_hi_c[0])
        |=> ptr[0] == AW'($past(ptr[0]) + ONE_A);
  endproperty
  a_acc_inc: assert property (p_acc_inc)
    else $error("pair 0 did not step up");

  property p_acc_dec;
    @(posedge i_clk_sys) disable iff (i_reset)
      (dec_c[0] && !wr_lo_c[0] && !wr_hi_c[0])
        |=> ptr[0] == AW'($past(ptr[0]) - ONE_A);
  endproperty
  a_acc_dec: assert property (p_acc_dec)
    else $error("pair 0 did not step down");

  property p_inc_acc_addr;
    @(posedge i_clk_sys) disable iff (i_reset)
      (mem_go && op == IPA_OP_INC_ACC)
        |=> o_mem_addr == AW'($past(ptr[sel]) + ONE_A);
  endproperty
  a_inc_acc_addr: assert property (p_inc_acc_addr)
    else $error("pre-increment address wrong");

  property p_ofs_keep;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_req && op == IPA_OP_OFS_ACC && !hit_ptr && sel == 2'd0)
        |=> ptr[0] == $past(ptr[0]);
  endproperty
  a_ofs_keep: assert property (p_ofs_keep)
    else $error("offset access changed pointer");

  property p_virt_read_zero;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_req && !i_we && blocked) |=> o_ack && o_rdata == 8'h00;
  endproperty
  a_virt_read_zero: assert property (p_virt_read_zero)
    else $error("virtual target read not zero");

  property p_virt_write_nop;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_req && i_we && blocked) |=> !o_mem_req;
  endproperty
  a_virt_write_nop: assert property (p_virt_write_nop)
    else $error("virtual target write reached memory");

  property p_direct_mem;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_req && op == IPA_OP_NONE && !hit_ptr)
        |=> o_mem_req && o_mem_addr == $past(i_addr);
  endproperty
  a_direct_mem: assert property (p_direct_mem)
    else $error("direct access not passed on");
endmodule : ipa_indirect

// file: bench/ipa_mem_model.sv
// Purpose: Data memory and register space behind the indirect unit
// Assumes: Read data answers the current address combinationally
// Notes:   Outside a request the read bus carries a moving pattern
`timescale 1ns/1ps
module ipa_mem_model (
  // Clock
  input  wire logic                   i_clk_sys,
  // Memory request
  input  wire logic                   i_mem_req,
  input  wire logic                   i_mem_we,
  input  wire logic [ipa_pkg::AW-1:0] i_mem_addr,
  input  wire logic [ipa_pkg::DW-1:0] i_mem_wdata,
  // Read answer
  output logic [ipa_pkg::DW-1:0]      o_mem_rdata
);
  import ipa_pkg::*;
  logic [7:0] mem_r [4096];
  logic [7:0] junk_r;
  initial begin
    junk_r = 8'hA5;
    for (int i = 0; i < 4096; i++) mem_r[i] = 8'h00;
  end
  always @(posedge i_clk_sys) begin
    junk_r <= ~junk_r + 8'h3B;
    if (i_mem_req === 1'b1 && i_mem_we === 1'b1) begin
      mem_r[i_mem_addr] <= i_mem_wdata;
    end
  end
  assign o_mem_rdata = (i_mem_req === 1'b1) ? mem_r[i_mem_addr] : junk_r;
endmodule : ipa_mem_model

// file: bench/ipa_indirect_tb.sv
// Purpose: Self-checking bench for the indirect addressing unit
// Assumes: One access per request, answered one cycle later
// Notes:   Expected results queue up and a monitor pops them on ack
`timescale 1ns/1ps
module ipa_indirect_tb;
  import ipa_pkg::*;
  typedef struct packed {
    logic mem; logic we; logic [11:0] addr; logic [7:0] wd; logic [7:0] rd;
  } ipa_exp_t;
  localparam logic [7:0]  WV [4] = '{8'h01, 8'hFF, 8'h7F, 8'h81};
  localparam logic [11:0] VA [5] = '{PLAIN_A[1], ACC_DEC_A[1],
    ACC_INC_A[1], INC_ACC_A[1], OFS_ACC_A[1]};
  logic        i_clk_sys, i_reset, i_req, i_we;
  logic [11:0] i_addr, o_mem_addr, a;
  logic [7:0]  i_wdata, i_wreg, i_mem_rdata, o_mem_wdata, o_rdata, rb;
  logic        o_mem_req, o_mem_we, o_ack;
  logic [15:0] ptr [3];
  logic [7:0]  shadow [4096];
  logic [31:0] rng;
  ipa_exp_t    q [$];
  int          n_fail, n_tests;

  ipa_indirect ipa_indirect_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wreg(i_wreg), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(i_mem_rdata), .o_ack(o_ack), .o_rdata(o_rdata));
  ipa_mem_model ipa_mem_model_i (.i_clk_sys(i_clk_sys),
    .i_mem_req(o_mem_req), .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] rnd8();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : rnd8

  function automatic int kind(input logic [11:0] x, output int p);
    p = 0;
    for (int i = 0; i < NPAIR; i++) begin
      p = i;
      if (x == PLAIN_A[i]) return 0;
      if (x == ACC_DEC_A[i]) return 1;
      if (x == ACC_INC_A[i]) return 2;
      if (x == INC_ACC_A[i]) return 3;
      if (x == OFS_ACC_A[i]) return 4;
      if (x == PTR_LO_A[i]) return 5;
      if (x == PTR_HI_A[i]) return 6;
    end
    return -1;
  endfunction : kind

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (!ok) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic acc(input logic we, input logic [11:0] ad,
                     input logic [7:0] d, input logic [7:0] w);
    ipa_exp_t    e;
    int          k, p, k2, p2;
    logic [11:0] ea;
    logic        st;
    e = '{mem: 1'b0, we: we, addr: 12'h000, wd: d, rd: 8'h00};
    k = kind(ad, p);
    k2 = k;
    p2 = p;
    ea = ad;
    if (k >= 0 && k <= 4) begin
      ea = ptr[p][11:0] + ((k == 4) ? {{4{w[7]}}, w} :
                           (k == 3) ? 12'h001 : 12'h000);
      k2 = kind(ea, p2);
    end
    // No step on a virtual target or on a write onto the own pair
    st = k >= 1 && k <= 3 && !(k2 >= 0 && k2 <= 4) &&
         !(we && k2 >= 5 && p2 == p);
    if (k2 >= 5) begin
      if (we && k2 == 5) ptr[p2][7:0] = d;
      else if (we) ptr[p2][15:8] = d;
      e.rd = (k2 == 5) ? ptr[p2][7:0] : {4'h0, ptr[p2][11:8]};
    end else if (k2 < 0) begin
      e.mem = 1'b1;
      e.addr = ea;
      if (we) shadow[ea] = d;
      else e.rd = shadow[ea];
    end
    if (st && k == 1) ptr[p] = ptr[p] - 16'h0001;
    if (st && k != 1) ptr[p] = ptr[p] + 16'h0001;
    q.push_back(e);
    i_req = 1'b1;
    i_we = we;
    i_addr = ad;
    i_wdata = d;
    i_wreg = w;
    @(posedge i_clk_sys);
    #1;
  endtask : acc

  task automatic setp(input int i, input logic [7:0] lo, input logic [7:0] hi);
    acc(1'b1, PTR_LO_A[i], lo, rnd8());
    acc(1'b1, PTR_HI_A[i], hi, rnd8());
  endtask : setp

  task automatic endtest(input string s);
    i_req = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    $display("test %s done", s);
  endtask : endtest

  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ****************************************
  // Clock, monitor, watchdog
  // ****************************************
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  always @(negedge i_clk_sys) begin : mon
    ipa_exp_t e;
    if (i_reset === 1'b0) begin
      if (o_ack === 1'b1 && q.size() > 0) begin
        e = q.pop_front();
        chk(o_mem_req === e.mem, "memory request");
        if (e.mem) chk(o_mem_addr === e.addr, "address");
        if (e.mem) chk(o_mem_we === e.we, "write strobe");
        if (e.mem && e.we) chk(o_mem_wdata === e.wd, "wdata");
        if (!e.we) chk(o_rdata === e.rd, "read data");
      end else if (o_ack !== 1'b0 || o_mem_req !== 1'b0) begin
        chk(1'b0, "stray answer");
      end
    end
  end

  initial begin
    #200000;
    chk(1'b0, "watchdog");
    print_verdict();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {i_reset, i_req, i_we, i_addr, i_wdata, i_wreg} = {2'b10, 29'h0000_0000};
    rng = 32'h0001_0506;
    n_fail = 0;
    n_tests = 0;
    for (int i = 0; i < 4096; i++) shadow[i] = 8'h00;
    foreach (ptr[i]) ptr[i] = 16'h0000;
    repeat (16) @(posedge i_clk_sys);
    #1;
    i_reset = 1'b0;
    for (int i = 0; i < NPAIR; i++) begin
      acc(1'b0, PTR_LO_A[i], 8'h00, 8'h00);
      acc(1'b0, PTR_HI_A[i], 8'h00, 8'h00);
    end
    endtest("reset");
    for (int i = 0; i < NPAIR; i++) setp(i, 8'hFE, 8'hF1 + 8'(i));
    for (int i = 0; i < NPAIR; i++) begin
      acc(1'b0, PTR_HI_A[i], 8'h00, 8'h00);
      repeat (4) acc(1'b1, ACC_INC_A[i], rnd8(), 8'h00);
      acc(1'b0, PTR_HI_A[i], 8'h00, 8'h00);
      repeat (5) acc(1'b0, ACC_DEC_A[i], 8'h00, 8'h00);
      acc(1'b0, PTR_HI_A[i], 8'h00, 8'h00);
      acc(1'b0, INC_ACC_A[i], 8'h00, 8'h00);
      repeat (2) acc(1'b0, PLAIN_A[i], 8'h00, 8'h00);
      foreach (WV[j]) acc(1'b1, OFS_ACC_A[i], rnd8(), WV[j]);
      foreach (WV[j]) acc(1'b0, OFS_ACC_A[i], 8'h00, WV[j]);
      acc(1'b0, PTR_LO_A[i], 8'h00, 8'h00);
      acc(1'b0, PTR_HI_A[i], 8'h00, 8'h00);
    end
    endtest("operands");
    setp(0, 8'h80, 8'h0F);
    acc(1'b1, PLAIN_A[0], rnd8(), 8'h00);
    acc(1'b0, PLAIN_A[0], 8'h00, 8'h00);
    repeat (8) begin
      rb = rnd8();
      a = {1'b0, rb[2:0], rnd8()};
      acc(1'b1, a, rnd8(), rnd8());
      acc(1'b0, a, 8'h00, rnd8());
    end
    endtest("space");
    setp(1, 8'h40, 8'h05);
    acc(1'b1, PLAIN_A[1], 8'hC3, 8'h00);
    foreach (VA[j]) begin
      setp(0, VA[j][7:0], {4'h0, VA[j][11:8]});
      acc(1'b0, PLAIN_A[0], 8'h00, 8'h00);
      acc(1'b1, PLAIN_A[0], 8'h5A, 8'h00);
    end
    acc(1'b0, PLAIN_A[1], 8'h00, 8'h00);
    acc(1'b0, PTR_LO_A[1], 8'h00, 8'h00);
    endtest("virtual target");
    setp(2, 8'hD9, 8'h0F);
    acc(1'b1, ACC_DEC_A[2], 8'h34, 8'h00);
    acc(1'b0, PTR_LO_A[2], 8'h00, 8'h00);
    setp(2, 8'hD9, 8'h0F);
    acc(1'b1, PLAIN_A[2], 8'h56, 8'h00);
    acc(1'b0, PTR_LO_A[2], 8'h00, 8'h00);
    acc(1'b0, PTR_HI_A[2], 8'h00, 8'h00);
    setp(2, 8'hD8, 8'h0F);
    acc(1'b1, INC_ACC_A[2], 8'h77, 8'h00);
    acc(1'b0, PTR_LO_A[2], 8'h00, 8'h00);
    acc(1'b0, PTR_HI_A[2], 8'h00, 8'h00);
    setp(0, 8'hE1, 8'h0F);
    acc(1'b1, ACC_INC_A[0], 8'hAB, 8'h00);
    acc(1'b0, PTR_LO_A[0], 8'h00, 8'h00);
    acc(1'b0, PTR_LO_A[1], 8'h00, 8'h00);
    endtest("own pair");
    chk(q.size() == 0, "answers missing");
    print_verdict();
  end
endmodule : ipa_indirect_tb
